// File: rtl/sfms_mask_rom.sv
// Sense mask interval lookup: torque column and sine step code to cycle count.
// Assumes the torque index is already decoded; an index above 7 reads as column 7; the answer is registered.
`default_nettype none

module sfms_mask_rom (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic [3:0] torque_idx,
	input wire logic [4:0] sine_code,
	output var logic [sfms_pkg::MASK_W-1:0] mask_cyc_ff
);
	import sfms_pkg::*;

	localparam logic [MASK_W-1:0] C090 = MASK_W'(MASK_0P90_CYC);
	localparam logic [MASK_W-1:0] C120 = MASK_W'(MASK_1P20_CYC);
	localparam logic [MASK_W-1:0] C150 = MASK_W'(MASK_1P50_CYC);
	localparam logic [MASK_W-1:0] C180 = MASK_W'(MASK_1P80_CYC);

	// Column 7 is the lowest torque; an out-of-range index is read as that column.
	function automatic logic [MASK_W-1:0] lookup(input logic [3:0] t, input logic [4:0] s);
		logic [3:0] c;
		c = (t > 4'h7) ? 4'h7 : t;
		lookup = C090;
		if (s >= 5'h10) begin
			lookup = (c <= 4'h1) ? C180 : (c <= 4'h4) ? C150 : (c <= 4'h6) ? C120 : C090;
		end else if (s >= 5'h08) begin
			lookup = (c <= 4'h2) ? C150 : (c <= 4'h5) ? C120 : C090;
		end else if (s >= 5'h04) begin
			lookup = (c <= 4'h2) ? C120 : C090;
		end
	endfunction

	wire logic [MASK_W-1:0] nxt_mask_cyc = lookup(torque_idx, sine_code);

	// The table is re-read every cycle so a step change lands on the next chop.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_cyc_ff <= C090;
		end else if (ce) begin
			mask_cyc_ff <= nxt_mask_cyc;
		end
	end

	chk_rom_low_codes: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		sine_code < 5'h04 |=> mask_cyc_ff == C090) else $error("mask not minimal at low code");
	chk_rom_full_torque: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		(sine_code >= 5'h10 && torque_idx == 4'h0) |=> mask_cyc_ff == C180)
		else $error("full torque high code mask wrong");

endmodule

`default_nettype wire

// File: rtl/sfms_pkg.sv
// Shared constants and carrier types of the stepper fault and mode supervisor.
// Assumes a single 50 MHz clock; every time below is turned into whole cycles here.
`default_nettype none

package sfms_pkg;

	// Clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 20;

	// Sense mask intervals as printed, in nanoseconds.
	localparam int MASK_0P90_NS = 900;
	localparam int MASK_1P20_NS = 1200;
	localparam int MASK_1P50_NS = 1500;
	localparam int MASK_1P80_NS = 1800;

	// Delays without a printed figure; plain defaults, in nanoseconds.
	localparam int OC_DEGLITCH_NS = 2000;
	localparam int FAULT_RETRY_NS = 1000000;
	localparam int SHUTDOWN_ENTRY_NS = 1000;
	localparam int POWER_UP_SETTLE_NS = 1000000;

	// Least times round up to whole cycles.
	localparam int MASK_0P90_CYC = (MASK_0P90_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MASK_1P20_CYC = (MASK_1P20_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MASK_1P50_CYC = (MASK_1P50_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MASK_1P80_CYC = (MASK_1P80_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_DEGLITCH_CYC = (OC_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_RETRY_CYC = (FAULT_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHUTDOWN_ENTRY_CYC = (SHUTDOWN_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWER_UP_SETTLE_CYC = (POWER_UP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Counter widths.
	localparam int MASK_W = 7;
	localparam int CNT_W = 17;
	localparam int POS_W = 8;

	// Tri-level pin codes: driven low, left open, driven high.
	localparam logic [1:0] TRI_LOW = 2'h0;
	localparam logic [1:0] TRI_OPEN = 2'h1;
	localparam logic [1:0] TRI_HIGH = 2'h2;

	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_POSITION = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;

	// Field positions and reset values.
	localparam int CTRL_SOFT_DIS_BIT = 0;
	localparam logic CTRL_SOFT_DIS_RST = 1'b0;
	localparam int ST_OC0_BIT = 0;
	localparam int ST_OC1_BIT = 1;
	localparam int ST_OT_BIT = 2;
	localparam int ST_SL_BIT = 3;
	localparam int ST_SLEEP_BIT = 4;
	localparam int ST_DIS_BIT = 5;
	localparam int ST_FAULT_BIT = 6;

	// Pins arriving from outside the clock domain.
	typedef struct packed {
		logic low_power_request_n;
		logic output_enable_n;
		logic step;
		logic over_temp;
		logic supply_low;
		logic [3:0] curr_limit;
		logic [1:0] sense_input;
		logic [1:0] torque_hi;
		logic [1:0] torque_lo;
	} sfms_pin_t;

	// Low-power sequencing states.
	typedef enum logic [1:0] {
		SLP_AWAKE,
		SLP_ENTERING,
		SLP_ASLEEP,
		SLP_WAKING
	} sfms_slp_t;

endpackage

`default_nettype wire

// File: rtl/sfms_top.sv
// Stepper fault and mode supervisor: sense masking, fault handling, sleep and enable.
// Assumes pin inputs are asynchronous, sine code and drive_on come from same-clock logic,
// and an AHB-Lite master that only issues single word transfers.
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none

// Notes on behaviour
// - Tri-level torque pins select nine scales; the last two share mask table column 7.
// - Sine codes 16-31: mask 1.80, 1.50, 1.20 or 0.90 us by torque.
// - Sine codes 8-15: mask 1.50, 1.20 or 0.90 us by torque.
// - Sine codes 4-7: 1.20 us at top three torques, else 0.90 us.
// - Sine codes 0-3: mask is 0.90 us at every torque.
// - Current limit held past deglitch time shuts bridge and lowers fault.
// - Shut bridge stays off for the retry interval, then drives again.
// - Each bridge has its own detection, deglitch and shutdown state.
// - High-side or low-side current limit both count as overcurrent.
// - Overcurrent uses only per-transistor limit signals, never sense inputs.
// - Over-temperature disables all bridges and lowers the fault pin.
// - Temperature clearing resumes by itself; fault released after resuming.
// - Supply low holds all logic and indexer in reset, fault low.
// - Supply recovered resumes operation, fault released afterwards.
// - Fault pin is unlatched and needs no clearing action.
// - Low-power request low turns off regulator, bridges and indexer.
// - Low power entered only after shutdown entry delay from falling request.
// - After wake request, outputs unchanged until power-up settle delay.
// - Output enable high disables bridges but keeps logic and regulator.
// - Steps advance indexer while disabled; bridges apply on re-enable.
// - Sense comparator ignored for mask interval after current turns on.
module sfms_top #(
	parameter int RETRY_CYC = sfms_pkg::FAULT_RETRY_CYC,
	parameter int WAKE_CYC = sfms_pkg::POWER_UP_SETTLE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire sfms_pkg::sfms_pin_t pins,
	input wire logic [4:0] sine_code,
	input wire logic [1:0] drive_on,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [1:0] bridge_enable,
	output logic regulator_enable,
	output logic indexer_enable,
	output logic [1:0] sense_trip,
	output logic [sfms_pkg::POS_W-1:0] applied_position,
	output logic fault_indicator_n_o,
	output logic fault_indicator_n_oe
);
	import sfms_pkg::*;

	localparam logic [CNT_W-1:0] DEG_LAST = CNT_W'(OC_DEGLITCH_CYC - 1);
	localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYC - 1);
	localparam logic [CNT_W-1:0] ENTRY_LAST = CNT_W'(SHUTDOWN_ENTRY_CYC - 1);
	localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 1);
	// Idle pin levels; the sleep request idles high, so a zero reset would fake a request.
	localparam sfms_pin_t PIN_IDLE = '{low_power_request_n: 1'b1, default: '0};

	// Maps a tri-level pin code to its column digit; an illegal code reads as open.
	function automatic logic [1:0] tri_digit(input logic [1:0] p);
		tri_digit = (p == TRI_LOW) ? 2'h0 : (p == TRI_HIGH) ? 2'h2 : 2'h1;
	endfunction

	// Pin synchronisers and agreement filter.
	sfms_pin_t sync1_ff, sync2_ff, sync3_ff, filt_ff;
	wire sfms_pin_t nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff ^ sync3_ff));

	// Three stages; a bit only moves once the second and third stage agree.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_ff <= PIN_IDLE;
			sync2_ff <= PIN_IDLE;
			sync3_ff <= PIN_IDLE;
			filt_ff <= PIN_IDLE;
		end else if (ce) begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			filt_ff <= nxt_filt;
		end
	end

	// Filtered pin views.
	wire logic sl = filt_ff.supply_low;
	wire logic ot = filt_ff.over_temp;
	wire logic lp_req_n = filt_ff.low_power_request_n;
	wire logic [3:0] torque_idx = 4'(tri_digit(filt_ff.torque_hi)) * 4'h3 +
		4'(tri_digit(filt_ff.torque_lo));

	// Either transistor of a bridge reporting its limit is an overcurrent.
	wire logic [1:0] lim_act = {|filt_ff.curr_limit[3:2], |filt_ff.curr_limit[1:0]};

	// Bus-visible control.
	logic soft_dis_ff;
	wire logic oe_dis = filt_ff.output_enable_n | soft_dis_ff;

	// Overcurrent state, one set per bridge.
	logic [1:0] oc_shut_ff;
	logic [CNT_W-1:0] oc_cnt_ff [2];

	// Deglitch while the limit holds, then count out the retry interval.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			oc_shut_ff <= '0;
			oc_cnt_ff[0] <= '0;
			oc_cnt_ff[1] <= '0;
		end else if (ce) begin
			for (int b = 0; b < 2; b++) begin
				if (sl) begin
					oc_shut_ff[b] <= 1'b0;
					oc_cnt_ff[b] <= '0;
				end else if (oc_shut_ff[b]) begin
					oc_shut_ff[b] <= (oc_cnt_ff[b] != RETRY_LAST);
					oc_cnt_ff[b] <= (oc_cnt_ff[b] == RETRY_LAST) ? '0 : oc_cnt_ff[b] + 1'b1;
				end else if (lim_act[b]) begin
					oc_shut_ff[b] <= (oc_cnt_ff[b] == DEG_LAST);
					oc_cnt_ff[b] <= (oc_cnt_ff[b] == DEG_LAST) ? '0 : oc_cnt_ff[b] + 1'b1;
				end else begin
					oc_cnt_ff[b] <= '0;
				end
			end
		end
	end

	// Low-power sequencer.
	sfms_slp_t slp_st_ff, nxt_slp_st;
	logic [CNT_W-1:0] slp_cnt_ff, nxt_slp_cnt;

	// A request that bounces back before the delay ends abandons the transition.
	always_comb begin
		nxt_slp_st = slp_st_ff;
		nxt_slp_cnt = '0;
		case (slp_st_ff)
			SLP_AWAKE: begin
				if (!lp_req_n) begin
					nxt_slp_st = SLP_ENTERING;
				end
			end
			SLP_ENTERING: begin
				if (lp_req_n) begin
					nxt_slp_st = SLP_AWAKE;
				end else if (slp_cnt_ff == ENTRY_LAST) begin
					nxt_slp_st = SLP_ASLEEP;
				end else begin
					nxt_slp_cnt = slp_cnt_ff + 1'b1;
				end
			end
			SLP_ASLEEP: begin
				if (lp_req_n) begin
					nxt_slp_st = SLP_WAKING;
				end
			end
			SLP_WAKING: begin
				if (!lp_req_n) begin
					nxt_slp_st = SLP_ASLEEP;
				end else if (slp_cnt_ff == WAKE_LAST) begin
					nxt_slp_st = SLP_AWAKE;
				end else begin
					nxt_slp_cnt = slp_cnt_ff + 1'b1;
				end
			end
			default: begin
				nxt_slp_st = SLP_AWAKE;
			end
		endcase
	end

	// Supply low forces the sequencer back to its reset state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slp_st_ff <= SLP_AWAKE;
			slp_cnt_ff <= '0;
		end else if (ce) begin
			slp_st_ff <= sl ? SLP_AWAKE : nxt_slp_st;
			slp_cnt_ff <= sl ? '0 : nxt_slp_cnt;
		end
	end

	// Mode decode shared by the output stage.
	wire logic awake = (slp_st_ff == SLP_AWAKE) || (slp_st_ff == SLP_ENTERING);
	wire logic idx_live = !sl && awake;
	wire logic drive_ok = idx_live && !oe_dis && !ot;
	wire logic [1:0] nxt_bridge_en = {2{drive_ok}} & ~oc_shut_ff;
	wire logic fault_src = |oc_shut_ff | ot | sl;

	// Indexer position and the copy the bridges are allowed to show.
	logic step_prev_ff;
	logic [POS_W-1:0] pos_ff;
	logic [POS_W-1:0] applied_ff;
	wire logic step_rise = filt_ff.step && !step_prev_ff;

	// Steps keep counting while the bridges are off but the indexer is live; the copy only follows when enabled.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_prev_ff <= 1'b0;
			pos_ff <= '0;
			applied_ff <= '0;
		end else if (ce) begin
			step_prev_ff <= filt_ff.step;
			if (sl) begin
				pos_ff <= '0;
			end else if (idx_live && step_rise) begin
				pos_ff <= pos_ff + 1'b1;
			end
			if (sl) begin
				applied_ff <= '0;
			end else if (drive_ok) begin
				applied_ff <= pos_ff;
			end
		end
	end

	// Sense mask interval per bridge.
	logic [MASK_W-1:0] mask_cyc_ff;
	logic [MASK_W-1:0] mask_cnt_ff [2];
	logic [1:0] drive_prev_ff;
	logic [1:0] trip_ff;

	sfms_mask_rom u_mask_rom (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.torque_idx(torque_idx),
		.sine_code(sine_code),
		.mask_cyc_ff(mask_cyc_ff)
	);

	// The mask also forms the minimum drive time, since no trip is seen before it ends.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_prev_ff <= '0;
			trip_ff <= '0;
			mask_cnt_ff[0] <= '0;
			mask_cnt_ff[1] <= '0;
		end else if (ce) begin
			drive_prev_ff <= sl ? 2'h0 : drive_on;
			for (int b = 0; b < 2; b++) begin
				if (sl) begin
					mask_cnt_ff[b] <= '0;
				end else if (drive_on[b] && !drive_prev_ff[b]) begin
					mask_cnt_ff[b] <= mask_cyc_ff;
				end else if (mask_cnt_ff[b] != '0) begin
					mask_cnt_ff[b] <= mask_cnt_ff[b] - 1'b1;
				end
				trip_ff[b] <= !sl && drive_on[b] && drive_prev_ff[b] &&
					(mask_cnt_ff[b] == '0) && filt_ff.sense_input[b];
			end
		end
	end

	// Output stage: fault release trails the bridge restart by one cycle.
	logic [1:0] bridge_en_ff;
	logic reg_en_ff;
	logic idx_en_ff;
	logic fault_hold_ff;
	logic fault_oe_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bridge_en_ff <= '0;
			reg_en_ff <= 1'b0;
			idx_en_ff <= 1'b0;
			fault_hold_ff <= 1'b0;
			fault_oe_ff <= 1'b0;
		end else if (ce) begin
			bridge_en_ff <= nxt_bridge_en;
			reg_en_ff <= idx_live;
			idx_en_ff <= idx_live;
			fault_hold_ff <= fault_src;
			fault_oe_ff <= fault_src | fault_hold_ff;
		end
	end

	// AHB-Lite slave: zero wait states, read data registered at the address phase.
	logic dp_wr_ff;
	logic [7:0] dp_addr_ff;
	logic [31:0] rdata_ff;
	logic [31:0] status_word;
	logic [31:0] rd_mux;
	wire logic addr_take = hsel && htrans[1] && hready;
	wire logic ctrl_wr = dp_wr_ff && (dp_addr_ff == ADDR_CTRL);

	always_comb begin
		status_word = 32'h0;
		status_word[ST_OC0_BIT] = oc_shut_ff[0];
		status_word[ST_OC1_BIT] = oc_shut_ff[1];
		status_word[ST_OT_BIT] = ot;
		status_word[ST_SL_BIT] = sl;
		status_word[ST_SLEEP_BIT] = (slp_st_ff == SLP_ASLEEP);
		status_word[ST_DIS_BIT] = oe_dis;
		status_word[ST_FAULT_BIT] = fault_oe_ff;
	end

	// Unmapped offsets read as zero and ignore writes.
	always_comb begin
		case (haddr[7:0])
			ADDR_CTRL: rd_mux = 32'(soft_dis_ff) << CTRL_SOFT_DIS_BIT;
			ADDR_STATUS: rd_mux = status_word;
			ADDR_POSITION: rd_mux = 32'(pos_ff);
			ADDR_MASK: rd_mux = 32'(mask_cyc_ff);
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_ff <= 1'b0;
			dp_addr_ff <= 8'h00;
			rdata_ff <= 32'h0;
			soft_dis_ff <= CTRL_SOFT_DIS_RST;
		end else if (ce) begin
			dp_wr_ff <= addr_take && hwrite;
			dp_addr_ff <= haddr[7:0];
			if (addr_take && !hwrite) begin
				rdata_ff <= rd_mux;
			end
			if (ctrl_wr) begin
				soft_dis_ff <= hwdata[CTRL_SOFT_DIS_BIT];
			end
		end
	end

	// Port drive; the fault pin only ever pulls low.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;
	assign bridge_enable = bridge_en_ff;
	assign regulator_enable = reg_en_ff;
	assign indexer_enable = idx_en_ff;
	assign sense_trip = trip_ff;
	assign applied_position = applied_ff;
	assign fault_indicator_n_o = 1'b0;
	assign fault_indicator_n_oe = fault_oe_ff;

	// Checks.
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn || !ce);

	sequence s_ot_clear;
		$fell(ot) && !sl && (oc_shut_ff == 2'h0);
	endsequence

	chk_fault_follows_src: assert property (fault_src |=> fault_oe_ff)
		else $error("fault pin not low with active fault");
	chk_ot_bridges_off: assert property (ot |=> bridge_en_ff == 2'h0)
		else $error("bridge on during over-temperature");
	chk_ot_release_late: assert property (s_ot_clear |=> fault_oe_ff ##1 !fault_oe_ff)
		else $error("fault release not one cycle after resume");
	chk_oc_deglitch_end: assert property (!sl && !oc_shut_ff[0] && lim_act[0] &&
		oc_cnt_ff[0] == DEG_LAST |=> oc_shut_ff[0] ##1 bridge_en_ff[0] == 1'b0)
		else $error("overcurrent shutdown missing");
	chk_oc_retry_end: assert property (!sl && oc_shut_ff[1] && oc_cnt_ff[1] == RETRY_LAST
		|=> !oc_shut_ff[1]) else $error("retry did not release bridge");
	chk_oc_independent: assert property (oc_shut_ff == 2'h1 && drive_ok |=> bridge_en_ff[1])
		else $error("healthy bridge disabled by other bridge");
	chk_sleep_entry_path: assert property (slp_st_ff == SLP_ASLEEP && $past(slp_st_ff) !=
		SLP_ASLEEP |-> $past(slp_st_ff) == SLP_ENTERING && $past(slp_cnt_ff) == ENTRY_LAST)
		else $error("low power entered early");
	chk_sleep_all_off: assert property (slp_st_ff == SLP_ASLEEP && !sl |=>
		!reg_en_ff && !idx_en_ff && bridge_en_ff == 2'h0)
		else $error("circuits alive in low power");
	chk_wake_settle: assert property (slp_st_ff == SLP_WAKING |=> bridge_en_ff == 2'h0)
		else $error("outputs moved before settle delay");
	chk_mask_quiet: assert property ($rose(drive_on[0]) && !sl |=> !trip_ff[0] [*8])
		else $error("sense trip inside mask interval");
	chk_disabled_hold: assert property (!drive_ok && !sl |=> $stable(applied_ff))
		else $error("applied position moved while disabled");
	chk_supply_low_reset: assert property (sl |=> pos_ff == '0 && !idx_en_ff && fault_oe_ff)
		else $error("supply low did not hold reset");

endmodule

`default_nettype wire

// File: verification/sfms_ctl_model.sv
// Behavioural motion controller driving the sleep request, output enable and step pins.
// Assumes the bench calls its tasks one at a time from a single process.
`default_nettype none

module sfms_ctl_model #(
	parameter int SETTLE_CYC = 20
) (
	input wire logic hclk,
	output var logic low_power_request_n,
	output var logic output_enable_n,
	output var logic step
);
	timeunit 1ns;
	timeprecision 1ps;

	int quiet;

	// Idle: awake, outputs enabled, step low.
	initial begin
		low_power_request_n = 1'b1;
		output_enable_n = 1'b0;
		step = 1'b0;
		quiet = 0;
	end

	// Holds the request low for n cycles; a short hold is only used to provoke an abort.
	task automatic hold_sleep(input int n);
		@(posedge hclk);
		low_power_request_n <= 1'b0;
		repeat (n) @(posedge hclk);
	endtask

	// Raises the request; no steps are sent until the settle time has passed.
	task automatic wake();
		@(posedge hclk);
		low_power_request_n <= 1'b1;
		quiet = SETTLE_CYC + 8;
	endtask

	task automatic set_disable(input logic lvl);
		@(posedge hclk);
		output_enable_n <= lvl;
	endtask

	// Each pulse stays level for six cycles so the input filter sees it.
	task automatic steps(input int n);
		while (quiet > 0) begin
			@(posedge hclk);
			quiet--;
		end
		repeat (n) begin
			@(posedge hclk);
			step <= 1'b1;
			repeat (6) @(posedge hclk);
			step <= 1'b0;
			repeat (6) @(posedge hclk);
		end
	endtask
endmodule

`default_nettype wire

// File: verification/sfms_top_tb.sv
// Self-checking bench of the stepper fault and mode supervisor.
// Assumes the design's bus never inserts wait states; the watchdog still bounds every wait.
`default_nettype none

module stepper_fault_mode_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sfms_pkg::*;

	localparam int RETRY = 20;
	logic hclk, hresetn, hsel, hwrite, ot, sl, hreadyout, hresp, reg_en, idx_en, f_o, f_oe;
	logic lpr_n, oe_n, stp, ce;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, si, th, tl, drive_on, bridge_enable, sense_trip, bexp;
	logic [2:0] hsize;
	logic [3:0] cl;
	logic [4:0] sine_code;
	logic [POS_W-1:0] applied_position;
	sfms_pin_t pins;
	int errors, num_checks, exp_pos, k, code, n, br;
	int exp_q[$];
	int base[4] = '{0, 4, 8, 16};
	int wid[4] = '{4, 4, 8, 16};

	assign pins = '{lpr_n, oe_n, stp, ot, sl, cl, si, th, tl};

	sfms_top #(.RETRY_CYC(RETRY), .WAKE_CYC(20)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .pins(pins), .sine_code(sine_code),
		.drive_on(drive_on), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .bridge_enable(bridge_enable),
		.regulator_enable(reg_en), .indexer_enable(idx_en), .sense_trip(sense_trip),
		.applied_position(applied_position), .fault_indicator_n_o(f_o),
		.fault_indicator_n_oe(f_oe)
	);

	sfms_ctl_model i_ctl (
		.hclk(hclk), .low_power_request_n(lpr_n), .output_enable_n(oe_n), .step(stp)
	);

	// 50 MHz clock.
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	task automatic tally_and_finish();
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge hclk);
	endtask

	// One single word transfer; read data is taken at the edge that ends the data phase.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wait_oe(input logic lvl);
		for (k = 0; k < 300 && f_oe !== lvl; k++) @(negedge hclk);
		chk(f_oe, lvl);
	endtask

	// The bridges must already be back one cycle before the fault pin lets go.
	task automatic released(input logic [1:0] be);
		logic [1:0] prev;
		prev = bridge_enable;
		for (k = 0; k < 300 && f_oe !== 1'b0; k++) begin
			prev = bridge_enable;
			@(negedge hclk);
		end
		chk(f_oe, 1'b0);
		chk(prev, be);
		chk(bridge_enable, be);
	endtask

	// Reference mask interval in cycles for a sine code and torque column.
	function automatic int mask_exp(input int c, input int col);
		if (c >= 16)
			return col < 2 ? MASK_1P80_CYC : col < 5 ? MASK_1P50_CYC : col < 7 ? MASK_1P20_CYC : MASK_0P90_CYC;
		if (c >= 8)
			return col < 3 ? MASK_1P50_CYC : col < 6 ? MASK_1P20_CYC : MASK_0P90_CYC;
		if (c >= 4)
			return col < 3 ? MASK_1P20_CYC : MASK_0P90_CYC;
		return MASK_0P90_CYC;
	endfunction

	// Hang guard, far beyond the eleven hundred or so cycles the sequence needs.
	initial begin
		repeat (20000) @(posedge hclk);
		errors++;
		tally_and_finish();
	end

	initial begin
		{hresetn, hwrite, ot, sl} = 4'h0;
		hsel = 1'b1;
		ce = 1'b1;
		hsize = 3'h2;
		{haddr, hwdata} = 64'h0;
		{htrans, si, th, tl, drive_on} = 10'h000;
		cl = 4'h0;
		sine_code = 5'h00;
		void'($urandom(94287));
		tick(10);
		hresetn <= 1'b1;
		// Every torque column against a random code from each sine band.
		for (int h = 0; h < 3; h++) begin
			for (int l = 0; l < 3; l++) begin
				for (int b = 0; b < 4; b++) begin
					code = base[b] + int'($urandom % wid[b]);
					exp_q.push_back(mask_exp(code, 3 * h + l));
					@(posedge hclk);
					th <= 2'(h);
					tl <= 2'(l);
					sine_code <= 5'(code);
					tick(8);
					ahb(1'b0, ADDR_MASK, 32'h0);
					chk(rd, exp_q.pop_front());
				end
			end
		end
		// Sense held tripped: the trip flag waits out the full mask, and raises no fault.
		th <= TRI_LOW;
		tl <= TRI_LOW;
		sine_code <= 5'h1F;
		si <= 2'h1;
		tick(8);
		drive_on <= 2'h3;
		for (k = 0; k < 200 && sense_trip[0] !== 1'b1; k++) @(negedge hclk);
		chk(k >= MASK_1P80_CYC && k <= MASK_1P80_CYC + 6, 1'b1);
		chk(f_oe, 1'b0);
		si <= 2'h0;
		// Interrupted limit must not trip; a solid one trips just the chosen bridge.
		br = int'($urandom % 2);
		n = 2 * br + int'($urandom % 2);
		bexp = br ? 2'h1 : 2'h2;
		@(posedge hclk);
		cl <= 4'h1 << n;
		tick(60);
		cl <= 4'h0;
		tick(8);
		cl <= 4'h1 << n;
		tick(60);
		chk(f_oe, 1'b0);
		wait_oe(1'b1);
		chk(k >= 41 && k <= 48, 1'b1);
		chk(bridge_enable, bexp);
		cl <= 4'h0;
		tick(10);
		chk(bridge_enable, bexp);
		released(2'h3);
		// Over-temperature: both bridges off, logic still running.
		ot <= 1'b1;
		wait_oe(1'b1);
		chk(bridge_enable, 2'h0);
		chk(reg_en, 1'b1);
		ot <= 1'b0;
		released(2'h3);
		// Steps while disabled move the indexer but not the bridges.
		i_ctl.steps(2);
		exp_pos = 2;
		tick(4);
		chk(applied_position, exp_pos);
		i_ctl.set_disable(1'b1);
		n = 1 + int'($urandom % 4);
		i_ctl.steps(n);
		chk({bridge_enable, reg_en, idx_en}, 4'h3);
		ahb(1'b0, ADDR_POSITION, 32'h0);
		chk(rd, exp_pos + n);
		chk(applied_position, exp_pos);
		exp_pos += n;
		i_ctl.set_disable(1'b0);
		tick(8);
		chk(applied_position, exp_pos);
		// Soft disable through the control word, and an unmapped offset.
		ahb(1'b1, ADDR_CTRL, 32'h1);
		ahb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		chk(bridge_enable, 2'h0);
		ahb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b1, ADDR_CTRL, 32'h0);
		// A transfer without select is ignored by the slave.
		@(posedge hclk);
		hsel <= 1'b0;
		ahb(1'b1, ADDR_CTRL, 32'h1);
		hsel <= 1'b1;
		ahb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk(bridge_enable, 2'h3);
		// A frozen clock enable hides a short over-temperature pulse completely.
		@(posedge hclk);
		ce <= 1'b0;
		ot <= 1'b1;
		tick(10);
		chk(f_oe, 1'b0);
		ot <= 1'b0;
		tick(2);
		ce <= 1'b1;
		tick(8);
		chk({f_oe, bridge_enable}, 3'h3);
		// Short sleep request aborts; a long one sleeps only after the entry delay.
		i_ctl.hold_sleep(20);
		i_ctl.wake();
		tick(30);
		chk({bridge_enable, reg_en}, 3'h7);
		i_ctl.hold_sleep(30);
		chk(reg_en, 1'b1);
		tick(40);
		chk({bridge_enable, reg_en, idx_en}, 4'h0);
		i_ctl.steps(2);
		i_ctl.wake();
		tick(12);
		chk(bridge_enable, 2'h0);
		for (k = 0; k < 100 && bridge_enable !== 2'h3; k++) @(negedge hclk);
		chk(bridge_enable, 2'h3);
		ahb(1'b0, ADDR_POSITION, 32'h0);
		chk(rd, exp_pos);
		// Supply low resets the indexer and holds the fault pin until recovery.
		sl <= 1'b1;
		wait_oe(1'b1);
		chk(bridge_enable, 2'h0);
		ahb(1'b0, ADDR_POSITION, 32'h0);
		chk(rd, 32'h0);
		sl <= 1'b0;
		released(2'h3);
		tally_and_finish();
	end
endmodule

`default_nettype wire
